//--- verif/sdc_ext_ctrl.sv
// model of the external system controller driving release and hold pins
`timescale 1ns/100ps
module sdc_ext_ctrl (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // commands from the bench
    input wire logic rel_go,
    input wire logic [7:0] rel_len,
    input wire logic hold_on,
    // pins toward the device
    output logic stop_release_input,
    output logic bus_hold_request_n
);
    logic [7:0] rel_cnt_q;
    logic [7:0] rel_cnt_d;

    // release pulse length in clk cycles, loaded on command
    assign rel_cnt_d = rel_go ? rel_len : (rel_cnt_q != 8'h00) ? rel_cnt_q - 8'h01 : 8'h00;

    // pulse counter; the pin rises, stays up, then falls to start recovery
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rel_cnt_q <= 8'h00;
        end else begin
            rel_cnt_q <= rel_cnt_d;
        end
    end

    // release high while counting, low otherwise
    assign stop_release_input = (rel_cnt_q != 8'h00);
    // hold request is active low
    assign bus_hold_request_n = ~hold_on;
endmodule // sdc_ext_ctrl

//--- verif/tb_dsp_standby_controller.sv
// self-checking bench of the standby sequencer
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); end end
module tb_dsp_standby_controller;
    import sdc_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic halt_instr = 1'b0;
    logic stop_instr = 1'b0;
    logic [3:0] ext_int = 4'h1;
    logic [3:0] int_enable = 4'h0;
    logic [3:0] periph_req = 4'h0;
    logic [19:0] core_addr = 20'h12345;
    logic core_rd_n = 1'b1;
    logic core_wr_n = 1'b0;
    logic core_bus_strobe = 1'b1;
    logic rel_go = 1'b0;
    logic [7:0] rel_len = 8'h00;
    logic hold_on = 1'b0;
    logic stop_release_input, bus_hold_request_n, core_clk_en, pll_enable, boot_request;
    logic system_clock_output, halt_status_output, stop_status_output, memory_address_bus_oe;
    logic memory_data_bus_oe, memory_read_write_strobes_oe, memory_bus_strobe;
    logic bus_hold_acknowledge_n, bus_hold_acknowledge_n_oe;
    logic [15:0] reg_rdata;
    logic [3:0] core_periph_req;
    logic [1:0] clk_src_sel, memory_read_write_strobes;
    logic [19:0] memory_address_bus;
    int failures = 0;
    int n_tests = 0;
    int cyc = 0;
    int hi, dbl;

    // external clock keeps running throughout standby
    always #2 clk = ~clk;

    sdc_top sdc_top_i (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .halt_instr(halt_instr), .stop_instr(stop_instr), .ext_int(ext_int),
        .int_enable(int_enable), .periph_req(periph_req), .core_periph_req(core_periph_req),
        .core_addr(core_addr), .core_rd_n(core_rd_n), .core_wr_n(core_wr_n),
        .core_bus_strobe(core_bus_strobe),
        .stop_release_input(stop_release_input), .bus_hold_request_n(bus_hold_request_n),
        .clk_src_sel(clk_src_sel), .core_clk_en(core_clk_en), .pll_enable(pll_enable),
        .boot_request(boot_request), .system_clock_output(system_clock_output),
        .halt_status_output(halt_status_output), .stop_status_output(stop_status_output),
        .memory_address_bus(memory_address_bus), .memory_address_bus_oe(memory_address_bus_oe),
        .memory_data_bus_oe(memory_data_bus_oe),
        .memory_read_write_strobes(memory_read_write_strobes),
        .memory_read_write_strobes_oe(memory_read_write_strobes_oe),
        .memory_bus_strobe(memory_bus_strobe), .bus_hold_acknowledge_n(bus_hold_acknowledge_n),
        .bus_hold_acknowledge_n_oe(bus_hold_acknowledge_n_oe));

    sdc_ext_ctrl sdc_ext_ctrl_i (.clk(clk), .rst_n(resetn), .rel_go(rel_go),
        .rel_len(rel_len), .hold_on(hold_on), .stop_release_input(stop_release_input),
        .bus_hold_request_n(bus_hold_request_n));

    // verdict and end of run
    task end_sim;
        $display("checks %0d, errors %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // register write, one strobe cycle
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // register read, data compared in the following cycle
    task rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask

    // one-cycle halt or stop pulse, then settle
    task instr(input logic st);
        @(posedge clk);
        halt_instr <= ~st;
        stop_instr <= st;
        @(posedge clk);
        halt_instr <= 1'b0;
        stop_instr <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask

    // release pulse of len clk cycles from the partner
    task release_pin(input logic [7:0] len);
        @(posedge clk);
        rel_go <= 1'b1;
        rel_len <= len;
        @(posedge clk);
        rel_go <= 1'b0;
    endtask

    // bounded wait for standby to end
    task wait_idle(input int mx);
        int k;
        k = 0;
        while (halt_status_output !== 1'b0 && k < mx) begin
            @(posedge clk);
            #1;
            k++;
        end
    endtask

    // clock output high cycles and back-to-back highs over 16 cycles
    task count_clk;
        logic prev;
        prev = 1'b0;
        hi = 0;
        dbl = 0;
        repeat (16) begin
            @(posedge clk);
            #1;
            if (system_clock_output === 1'b1) hi++;
            if (prev === 1'b1 && system_clock_output === 1'b1) dbl++;
            prev = system_clock_output;
        end
    endtask

    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            end_sim;
        end
    end

    // main sequence
    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        rd(REG_CDC, CDC_RESET);
        wr(4'h2, 16'hffff);
        rd(4'h2, 16'h0000);
        `CHK(halt_status_output, 1'b0)
        `CHK(boot_request, 1'b0)
        wr(REG_CDC, 16'h0173);
        rd(REG_CDC, 16'h0173);
        // run mode: core strobes and data enable reach the pins
        `CHK({memory_read_write_strobes, memory_data_bus_oe, memory_bus_strobe}, 4'b1011)
        `CHK(clk_src_sel, SRC_PLL)
        // halt with the interrupt pending but not enabled
        instr(1'b0);
        `CHK({halt_status_output, stop_status_output}, 2'b10)
        `CHK(clk_src_sel, SRC_DIV)
        @(posedge clk);
        core_addr <= 20'habcde;
        core_bus_strobe <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        `CHK(memory_address_bus, 20'h12345)
        `CHK(memory_read_write_strobes, STROBES_IDLE)
        `CHK({bus_hold_acknowledge_n, bus_hold_acknowledge_n_oe}, 2'b11)
        `CHK(memory_bus_strobe, 1'b1)
        count_clk;
        `CHK(hi, 4)
        `CHK(dbl, 0)
        `CHK(halt_status_output, 1'b1)
        @(posedge clk);
        hold_on <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        `CHK(memory_address_bus_oe, 1'b0)
        `CHK({memory_read_write_strobes_oe, bus_hold_acknowledge_n_oe}, 2'b00)
        `CHK(memory_data_bus_oe, 1'b0)
        `CHK(memory_bus_strobe, 1'b0)
        @(posedge clk);
        hold_on <= 1'b0;
        int_enable <= 4'h1;
        repeat (10) @(posedge clk);
        #1;
        `CHK(halt_status_output, 1'b1)
        wait_idle(30);
        `CHK(halt_status_output, 1'b0)
        `CHK(clk_src_sel, SRC_PLL)
        @(posedge clk);
        int_enable <= 4'h0;
        // halt with the clock output disabled
        wr(REG_CDC, 16'h0153);
        instr(1'b0);
        count_clk;
        `CHK(hi, 0)
        @(posedge clk);
        int_enable <= 4'h1;
        wait_idle(30);
        `CHK(halt_status_output, 1'b0)
        wr(REG_CDC, 16'h0173);
        // stop: interrupts and a short release must not end it
        periph_req <= 4'hf;
        instr(1'b1);
        `CHK({halt_status_output, stop_status_output}, 2'b11)
        `CHK({core_clk_en, clk_src_sel}, {1'b0, SRC_DIV})
        `CHK(core_periph_req, 4'h0)
        `CHK(pll_enable, 1'b1)
        rd(REG_STAT, 16'h000b);
        release_pin(8'd40);
        repeat (60) @(posedge clk);
        #1;
        `CHK(stop_status_output, 1'b1)
        release_pin(8'd60);
        repeat (52) @(posedge clk);
        rd(REG_STAT, 16'h001b);
        `CHK(stop_status_output, 1'b1)
        wait_idle(20);
        `CHK({stop_status_output, core_clk_en}, 2'b01)
        `CHK(clk_src_sel, SRC_PLL)
        repeat (2) @(posedge clk);
        #1;
        `CHK(core_periph_req, 4'hf)
        @(posedge clk);
        int_enable <= 4'h0;
        // reset in the middle of halt
        instr(1'b0);
        @(posedge clk);
        resetn <= 1'b0;
        @(posedge clk);
        #1;
        `CHK({clk_src_sel, boot_request}, {SRC_EXT, 1'b1})
        `CHK(halt_status_output, 1'b0)
        end_sim;
    end
endmodule // tb_dsp_standby_controller

//--- verilog/sdc_divtick.sv
// programmable divider that marks one reference cycle per divided period
`timescale 1ns/100ps
module sdc_divtick
    import sdc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic run,
    input wire logic [3:0] rate,
    // divided-clock marker, high one cycle per period
    output logic tick
);
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic tick_d;

    // period is rate plus one reference cycles
    assign tick_d = run && (cnt_q == rate);
    assign cnt_d = (!run || tick_d) ? '0 : 4'(cnt_q + 4'h1);

    // counter and marker flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
            tick <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick <= tick_d;
        end
    end
endmodule // sdc_divtick

//--- verilog/sdc_pkg.sv
// shared constants and types of the dsp standby controller
package sdc_pkg;
    // register port geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    // register offsets
    localparam logic [3:0] REG_CDC = 4'h0;
    localparam logic [3:0] REG_STAT = 4'h1;
    // clock_divider_control fields
    localparam int CDC_RATE_LSB = 0;
    localparam int CDC_RATE_MSB = 3;
    localparam int CDC_DIV_RUN = 4;
    localparam int CDC_SYSTEM_CLOCK_OUTPUT_EN = 5;
    localparam int CDC_SRC_LSB = 6;
    localparam int CDC_SRC_MSB = 7;
    localparam int CDC_PLL_EN = 8;
    localparam logic [15:0] CDC_RESET = 16'h0120;
    // status register fields
    localparam int STAT_HALT = 0;
    localparam int STAT_STOP = 1;
    localparam int STAT_SRC_LSB = 2;
    localparam int STAT_SRC_MSB = 3;
    localparam int STAT_ARMED = 4;
    // clock source encodings
    localparam logic [1:0] SRC_EXT = 2'h0;
    localparam logic [1:0] SRC_PLL = 2'h1;
    localparam logic [1:0] SRC_DIV = 2'h2;
    // wake and release widths in divided-clock cycles
    localparam logic [2:0] HALT_WAKE_TICKS = 3'h4;
    localparam logic [3:0] STOP_REL_TICKS = 4'hc;
    // pin levels
    localparam logic [1:0] STROBES_IDLE = 2'h3;
    // standby sequencer states
    typedef enum logic [1:0] {
        ST_RUN,
        ST_HALT,
        ST_STOP,
        ST_STOP_ARMED
    } sdc_state_type;
endpackage

//--- verilog/sdc_top.sv
// standby sequencer: halt and stop entry, wake-up, clock source and pin states
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/100ps
// Functional notes
// - standby entered only by halt or stop
// - halt switches core clock to divided clock
// - halt wake needs enabled interrupt, four ticks
// - reset forces external clock, boot needed
// - halt holds pins, clock out, halt high
// - hold request floats bus, else strobes high
// - clock output disabled keeps pin low
// - standby clock output high one cycle
// - stop selects divided clock, masks core clock
// - stop left only by reset or release
// - pll runs in stop unless software stopped
// - stop holds pins, both status outputs high
// - no peripheral requests reach core in stop
// - recovery restores previous clock source
module sdc_top
    import sdc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // core instruction and interrupt side
    input wire logic halt_instr,
    input wire logic stop_instr,
    input wire logic [3:0] ext_int,
    input wire logic [3:0] int_enable,
    input wire logic [3:0] periph_req,
    output logic [3:0] core_periph_req,
    // core memory bus side
    input wire logic [19:0] core_addr,
    input wire logic core_rd_n,
    input wire logic core_wr_n,
    input wire logic core_bus_strobe,
    // external control pins
    input wire logic stop_release_input,
    input wire logic bus_hold_request_n,
    // clock control
    output logic [1:0] clk_src_sel,
    output logic core_clk_en,
    output logic pll_enable,
    output logic boot_request,
    output logic system_clock_output,
    // status pins
    output logic halt_status_output,
    output logic stop_status_output,
    // memory bus pins
    output logic [19:0] memory_address_bus,
    output logic memory_address_bus_oe,
    output logic memory_data_bus_oe,
    output logic [1:0] memory_read_write_strobes,
    output logic memory_read_write_strobes_oe,
    output logic memory_bus_strobe,
    output logic bus_hold_acknowledge_n,
    output logic bus_hold_acknowledge_n_oe
);
    logic rst_meta_q;
    logic rstn;
    sdc_state_type state_q;
    sdc_state_type state_d;
    logic [15:0] cdc_q;
    logic [15:0] cdc_d;
    logic [1:0] saved_src_q;
    logic [1:0] saved_src_d;
    logic [2:0] wake_cnt_q;
    logic [2:0] wake_cnt_d;
    logic [3:0] rel_cnt_q;
    logic [3:0] rel_cnt_d;
    logic div_tick;
    logic wake_any;
    logic wake_done;
    logic rel_done;
    logic entering;
    logic standby_d;
    logic stop_d;
    logic float_bus;
    logic [1:0] cdc_src;
    logic system_clock_output_en;
    logic [15:0] stat_word;
    logic [15:0] rdata_d;
    logic [1:0] src_d;
    logic system_clock_output_d;
    logic [19:0] addr_d;
    logic data_oe_d;
    logic [1:0] strobes_d;
    logic bus_strobe_d;
    logic ack_n_d;
    logic ack_oe_d;

    // reset release through two flops
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_q <= 1'b0;
            rstn <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rstn <= rst_meta_q;
        end
    end

    // divided clock marker from the configured rate
    sdc_divtick u_div (
        .clk(clk),
        .rst_n(rstn),
        .run(cdc_q[CDC_DIV_RUN]),
        .rate(cdc_q[CDC_RATE_MSB:CDC_RATE_LSB]),
        .tick(div_tick)
    );

    // register decode and field views
    assign cdc_src = cdc_q[CDC_SRC_MSB:CDC_SRC_LSB];
    assign system_clock_output_en = cdc_q[CDC_SYSTEM_CLOCK_OUTPUT_EN];
    assign cdc_d = (reg_wr && reg_addr == REG_CDC) ? reg_wdata : cdc_q;
    assign stat_word = {11'h000, state_q == ST_STOP_ARMED, clk_src_sel,
                        stop_status_output, halt_status_output};
    assign rdata_d = !reg_rd ? '0 :
                     (reg_addr == REG_CDC) ? cdc_q :
                     (reg_addr == REG_STAT) ? stat_word : '0;

    // halt wake: enabled interrupt held for four divided cycles
    assign wake_any = |(ext_int & int_enable);
    assign wake_done = (state_q == ST_HALT) && wake_any && div_tick &&
                       (wake_cnt_q == 3'(HALT_WAKE_TICKS - 3'h1));
    assign wake_cnt_d = (state_q != ST_HALT || !wake_any) ? '0 :
                        div_tick ? 3'(wake_cnt_q + 3'h1) : wake_cnt_q;

    // stop release: release pin high for twelve divided cycles
    assign rel_done = (state_q == ST_STOP) && stop_release_input && div_tick &&
                      (rel_cnt_q == 4'(STOP_REL_TICKS - 4'h1));
    assign rel_cnt_d = (state_q != ST_STOP || !stop_release_input) ? '0 :
                       div_tick ? 4'(rel_cnt_q + 4'h1) : rel_cnt_q;

    // standby sequencer; divider is assumed started by software
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_RUN: begin
                if (stop_instr) begin
                    state_d = ST_STOP;
                end else if (halt_instr) begin
                    state_d = ST_HALT;
                end
            end
            ST_HALT: begin
                if (wake_done) begin
                    state_d = ST_RUN;
                end
            end
            ST_STOP: begin
                if (rel_done) begin
                    state_d = ST_STOP_ARMED;
                end
            end
            ST_STOP_ARMED: begin
                if (!stop_release_input) begin
                    state_d = ST_RUN;
                end
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
    end

    // clock source selection and restore on exit
    assign entering = (state_q == ST_RUN) && (state_d != ST_RUN);
    assign standby_d = (state_d != ST_RUN);
    assign stop_d = (state_d == ST_STOP) || (state_d == ST_STOP_ARMED);
    assign saved_src_d = entering ? cdc_src : saved_src_q;
    assign src_d = standby_d ? SRC_DIV :
                   (state_q != ST_RUN) ? saved_src_q : cdc_src;

    // clock output: one-cycle high marks in standby, toggling otherwise
    assign system_clock_output_d = !system_clock_output_en ? 1'b0 :
                      standby_d ? div_tick :
                      !system_clock_output;

    // memory bus pin states; address held in standby, bus strobe held unless hold request drives it low, strobes driven idle
    assign float_bus = !bus_hold_request_n;
    assign addr_d = standby_d ? memory_address_bus : core_addr;
    assign data_oe_d = !float_bus && !standby_d && !core_wr_n;
    assign strobes_d = standby_d ? STROBES_IDLE : {core_rd_n, core_wr_n};
    assign bus_strobe_d = !standby_d ? core_bus_strobe :
                          float_bus ? 1'b0 : memory_bus_strobe;
    assign ack_n_d = !(float_bus && !standby_d);
    assign ack_oe_d = !(float_bus && standby_d);

    // sequencer and configuration flops
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_RUN;
            cdc_q <= CDC_RESET;
            saved_src_q <= SRC_EXT;
            wake_cnt_q <= '0;
            rel_cnt_q <= '0;
        end else begin
            state_q <= state_d;
            cdc_q <= cdc_d;
            saved_src_q <= saved_src_d;
            wake_cnt_q <= wake_cnt_d;
            rel_cnt_q <= rel_cnt_d;
        end
    end

    // clock control and status outputs; reset picks the external clock
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            clk_src_sel <= SRC_EXT;
            boot_request <= 1'b1;
            core_clk_en <= 1'b1;
            pll_enable <= CDC_RESET[CDC_PLL_EN];
            system_clock_output <= 1'b0;
            halt_status_output <= 1'b0;
            stop_status_output <= 1'b0;
            core_periph_req <= '0;
            reg_rdata <= '0;
        end else begin
            clk_src_sel <= src_d;
            boot_request <= 1'b0;
            core_clk_en <= !stop_d;
            pll_enable <= cdc_d[CDC_PLL_EN];
            system_clock_output <= system_clock_output_d;
            halt_status_output <= standby_d;
            stop_status_output <= stop_d;
            core_periph_req <= stop_d ? '0 : periph_req;
            reg_rdata <= rdata_d;
        end
    end

    // memory bus pin flops, reset to address low and strobes high
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            memory_address_bus <= '0;
            memory_address_bus_oe <= 1'b1;
            memory_data_bus_oe <= 1'b0;
            memory_read_write_strobes <= STROBES_IDLE;
            memory_read_write_strobes_oe <= 1'b1;
            memory_bus_strobe <= 1'b1;
            bus_hold_acknowledge_n <= 1'b1;
            bus_hold_acknowledge_n_oe <= 1'b1;
        end else begin
            memory_address_bus <= addr_d;
            memory_address_bus_oe <= !float_bus;
            memory_data_bus_oe <= data_oe_d;
            memory_read_write_strobes <= strobes_d;
            memory_read_write_strobes_oe <= !float_bus;
            memory_bus_strobe <= bus_strobe_d;
            bus_hold_acknowledge_n <= ack_n_d;
            bus_hold_acknowledge_n_oe <= ack_oe_d;
        end
    end

    // checks on sequencing, clocking and pins
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    property p_entry_only;
        $rose(halt_status_output) |-> $past(halt_instr || stop_instr);
    endproperty
    a_entry_only: assert property (p_entry_only)
        else $error("standby entered without instruction");

    property p_halt_src;
        (state_q == ST_RUN && halt_instr && !stop_instr) |=>
            (clk_src_sel == SRC_DIV && halt_status_output && !stop_status_output);
    endproperty
    a_halt_src: assert property (p_halt_src)
        else $error("halt did not select divided clock");

    property p_halt_wake;
        (state_q == ST_HALT && wake_any && div_tick &&
         wake_cnt_q == 3'(HALT_WAKE_TICKS - 3'h1)) |=>
            (state_q == ST_RUN);
    endproperty
    a_halt_wake: assert property (p_halt_wake)
        else $error("halt not released after four ticks");

    property p_halt_early;
        (state_q == ST_HALT && (wake_cnt_q < 3'(HALT_WAKE_TICKS - 3'h1) || !wake_any)) |=>
            (state_q == ST_HALT);
    endproperty
    a_halt_early: assert property (p_halt_early)
        else $error("halt released too early");

    property p_boot;
        boot_request |-> (clk_src_sel == SRC_EXT && !halt_status_output) ##1 !boot_request;
    endproperty
    a_boot: assert property (p_boot)
        else $error("reset did not force external clock");

    property p_system_clock_output_off;
        !system_clock_output_en |=> !system_clock_output;
    endproperty
    a_system_clock_output_off: assert property (p_system_clock_output_off)
        else $error("clock output active while disabled");

    property p_system_clock_output_pulse;
        (halt_status_output && system_clock_output) |=>
            (!system_clock_output || !halt_status_output ||
             cdc_q[CDC_RATE_MSB:CDC_RATE_LSB] == '0);
    endproperty
    a_system_clock_output_pulse: assert property (p_system_clock_output_pulse)
        else $error("standby clock output high too long");

    property p_stop_mask;
        stop_status_output |-> (!core_clk_en && clk_src_sel == SRC_DIV
                                && halt_status_output);
    endproperty
    a_stop_mask: assert property (p_stop_mask)
        else $error("stop mode without masked divided clock");

    property p_stop_hold;
        (state_q == ST_STOP && !stop_release_input) |=> (state_q == ST_STOP);
    endproperty
    a_stop_hold: assert property (p_stop_hold)
        else $error("stop left without release");

    property p_periph;
        stop_status_output |-> (core_periph_req == 4'h0);
    endproperty
    a_periph: assert property (p_periph)
        else $error("peripheral request passed in stop");

    property p_restore;
        $fell(halt_status_output) |-> (clk_src_sel == saved_src_q && !stop_status_output);
    endproperty
    a_restore: assert property (p_restore)
        else $error("clock source not restored");

    property p_float;
        (state_q != ST_RUN && state_d != ST_RUN && !bus_hold_request_n) |=>
            (!memory_address_bus_oe && !bus_hold_acknowledge_n_oe
             && !memory_read_write_strobes_oe);
    endproperty
    a_float: assert property (p_float)
        else $error("bus not floated under hold in halt");

    property p_addr_keep;
        (state_q != ST_RUN && state_d != ST_RUN) |=> $stable(memory_address_bus);
    endproperty
    a_addr_keep: assert property (p_addr_keep)
        else $error("address changed in standby");

    c_halt_wake: cover property (state_q == ST_HALT ##1 state_q == ST_RUN);
    c_stop_rel: cover property (state_q == ST_STOP_ARMED ##1 state_q == ST_RUN);
    c_system_clock_output: cover property (halt_status_output && system_clock_output);
    c_float: cover property (halt_status_output && !memory_address_bus_oe);
endmodule // sdc_top
